// file: core/sysopt_pkg.sv
// constants, types and settings shared by the option control block
// assumes a single 40 mhz system clock and a plain register port
//
// Behaviour
// - each unit primary or secondary, default primary
// - one validity flag per unit, default valid
// - invalid unit adopts valid peer set, becomes valid
// - both valid but differing: secondary adopts primary
// - mismatch pairs blink ready and block data
// - role, name, speed, clock settings stay local
// - exchange starts on every reset or reinit
// - full reset on power, test command, switch
// - reinit on setting change, restart, minute link loss
// - idle timeout 1 to 255 minutes, default 20
// - idle timeout only with channel enable set
// - shared char format, default eight bits none
// - shared stop bits 1, 1.5, 2, default 1
// - system signal policy used where channel none
// - dial values make channel run modem handshake
// - dial star lets modem place outgoing calls
// - assert drives carrier, dsr, cts, forwards nothing
// - assert star drops signals briefly on disconnect
// - pass relays modem signal transitions across
// - escape one or two codes 00-1f, default 1c1c
// - escape on async/switched enters command mode
// - escape needs terminal and echo enables set
package sysopt_pkg;
   // register indices on the plain port
   localparam logic [3:0] reg_ctrl      = 4'h0;  // role, validity, format, policy
   localparam logic [3:0] reg_timeout   = 4'h1;  // idle minutes
   localparam logic [3:0] reg_escape    = 4'h2;  // escape characters
   localparam logic [3:0] reg_command   = 4'h3;  // restart, test, exchange
   localparam logic [3:0] reg_status    = 4'h4;  // state flags
   localparam logic [3:0] reg_chan_cfg  = 4'h5;  // per channel enables
   localparam logic [3:0] reg_chan_sig  = 4'h6;  // per channel signal setting
   localparam logic [3:0] reg_link      = 4'h7;  // link speed
   localparam logic [3:0] reg_shared    = 4'h8;  // exchanged parameter word
   // control field positions
   localparam int ctrl_role_bit  = 0;
   localparam int ctrl_valid_bit = 1;
   localparam int ctrl_bits_lo   = 2;
   localparam int ctrl_par_lo    = 4;
   localparam int ctrl_stop_lo   = 6;
   localparam int ctrl_pol_bit   = 8;
   localparam int ctrl_star_bit  = 9;
   // encodings, limits and reset values
   localparam logic        role_primary  = 1'b1;
   localparam logic        flag_valid    = 1'b1;
   localparam logic [1:0]  bits_eight    = 2'h3;
   localparam logic [1:0]  par_none      = 2'h0;
   localparam logic [1:0]  par_odd       = 2'h1;
   localparam logic [1:0]  par_even      = 2'h2;
   localparam logic [1:0]  stop_one      = 2'h0;
   localparam logic [1:0]  stop_one_half = 2'h1;
   localparam logic [1:0]  stop_two      = 2'h2;
   localparam logic        pol_assert    = 1'b0;
   localparam logic        pol_pass      = 1'b1;
   localparam logic [7:0]  timeout_def   = 8'h14;
   localparam logic [7:0]  timeout_min   = 8'h01;
   localparam logic [4:0]  escape_def    = 5'h1c;
   localparam logic [4:0]  escape_max    = 5'h1f;
   // channel signal settings
   localparam logic [2:0]  sig_none      = 3'h0;
   localparam logic [2:0]  sig_pass      = 3'h1;
   localparam logic [2:0]  sig_assert    = 3'h2;
   localparam logic [2:0]  sig_assert_st = 3'h3;
   localparam logic [2:0]  sig_dial      = 3'h4;
   localparam logic [2:0]  sig_dial_st   = 3'h5;
   // channel types
   localparam logic [1:0]  ch_async      = 2'h0;
   localparam logic [1:0]  ch_switched   = 2'h1;
   localparam logic [1:0]  ch_sync       = 2'h2;
   localparam logic [1:0]  ch_block      = 2'h3;
   // timing
   localparam longint clk_hz        = 40000000;
   localparam longint minute_s      = 60;
   localparam longint minute_cycles = clk_hz * minute_s;
   localparam int     drop_ns       = 1000;
   localparam int     drop_cycles   = (drop_ns + 24) / 25;
   // exchange sequencer states
   typedef enum logic [4:0] {
      st_idle = 5'b00001,
      st_send = 5'b00010,
      st_wait = 5'b00100,
      st_fail = 5'b01000,
      st_run  = 5'b10000
   } xchg_state_t;
endpackage : sysopt_pkg

// file: core/chan_ctl.sv
// per channel idle timer, escape matcher and modem signal policy
// assumes minute tick and data strobes on sys_clk, modem inputs synchronised
`timescale 1ns/10ps
`default_nettype none
module chan_ctl
   import sysopt_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   // settings
   input  wire logic [1:0] chan_type,
   input  wire logic [2:0] chan_sig,
   input  wire logic       sys_pol,
   input  wire logic       idle_en,
   input  wire logic       term_en,
   input  wire logic       echo_en,
   input  wire logic [7:0] timeout_min_cnt,
   input  wire logic [4:0] esc_a,
   input  wire logic [4:0] esc_b,
   input  wire logic       esc_two,
   // data and events
   input  wire logic       minute_tick,
   input  wire logic       char_strobe,
   input  wire logic [7:0] char_data,
   input  wire logic       data_allowed,
   input  wire logic       far_sigs,
   // results
   output logic            idle_disc,
   output logic            cmd_enter,
   output logic            sig_out,
   output logic            dial_handshake,
   output logic            dial_out_ok
);
   logic [7:0] idle_cnt;       // minutes without data
   logic       esc_half;       // first escape char seen
   logic [5:0] drop_cnt;       // brief drop timer
   logic [2:0] eff_sig;        // effective signal setting
   logic       switched;

   assign switched = (chan_type == ch_switched);
   // system policy where channel says none
   always_comb
   begin
      if (chan_sig == sig_none)
         eff_sig = (sys_pol == pol_pass) ? sig_pass : sig_assert;
      else
         eff_sig = chan_sig;
   end

   // idle minute counter
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         idle_cnt  <= 8'h00;
         idle_disc <= 1'b0;
      end
      else
      begin
         idle_disc <= 1'b0;
         if (char_strobe || !switched || !idle_en)
            idle_cnt <= 8'h00;
         else if (minute_tick)
         begin
            if (idle_cnt + 8'h01 >= timeout_min_cnt)
            begin
               idle_disc <= 1'b1;
               idle_cnt  <= 8'h00;
            end
            else
               idle_cnt <= idle_cnt + 8'h01;
         end
      end
   end

   // escape recognition
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         esc_half  <= 1'b0;
         cmd_enter <= 1'b0;
      end
      else
      begin
         cmd_enter <= 1'b0;
         if (char_strobe && term_en && echo_en && data_allowed
             && (chan_type == ch_async || switched))
         begin
            if (esc_two && esc_half && char_data == {3'h0, esc_b})
            begin
               cmd_enter <= 1'b1;
               esc_half  <= 1'b0;
            end
            else if (char_data == {3'h0, esc_a})
            begin
               cmd_enter <= !esc_two;
               esc_half  <= esc_two;
            end
            else
               esc_half <= 1'b0;
         end
      end
   end

   // modem signal output
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         drop_cnt       <= 6'h00;
         sig_out        <= 1'b0;
         dial_handshake <= 1'b0;
         dial_out_ok    <= 1'b0;
      end
      else
      begin
         dial_handshake <= (eff_sig == sig_dial) || (eff_sig == sig_dial_st);
         dial_out_ok    <= (eff_sig == sig_dial_st);
         if (idle_disc && eff_sig == sig_assert_st)
            drop_cnt <= 6'(drop_cycles);
         else if (drop_cnt != 6'h00)
            drop_cnt <= drop_cnt - 6'h01;
         case (eff_sig)
            sig_pass:      sig_out <= far_sigs;
            sig_assert:    sig_out <= 1'b1;
            sig_assert_st: sig_out <= (drop_cnt == 6'h00);
            default:       sig_out <= far_sigs;
         endcase
      end
   end
endmodule // chan_ctl
`default_nettype wire

// file: core/mux_system_option_control.sv
// system option control: roles, parameter exchange, reinit and channels
// assumes a peer link of strobed words and pin inputs needing sync
`timescale 1ns/10ps
`default_nettype none
module mux_system_option_control
   import sysopt_pkg::*;
#(
   parameter int     CHANNELS      = 4,
   parameter longint MINUTE_CYCLES = minute_cycles
)
(
   // clock and reset
   input  wire logic                sys_clk,
   input  wire logic                sys_rst,
   // register port
   input  wire logic [3:0]          reg_addr,
   input  wire logic [31:0]         reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic      [31:0]         reg_rdata,
   // pins
   input  wire logic                system_reset_switch,
   input  wire logic                link_up,
   // peer link words
   input  wire logic                peer_strobe,
   input  wire logic                peer_role,
   input  wire logic                peer_valid,
   input  wire logic [31:0]         peer_params,
   output logic                     tx_strobe,
   output logic                     tx_role,
   output logic                     tx_valid,
   output logic      [31:0]         tx_params,
   // channel data
   input  wire logic [CHANNELS-1:0] char_strobe,
   input  wire logic [7:0]          char_data,
   input  wire logic [CHANNELS-1:0] far_sigs,
   // status and channel outputs
   output logic                     ready_led,
   output logic                     data_enable,
   output logic                     full_diag,
   output logic [CHANNELS-1:0]      idle_disc,
   output logic [CHANNELS-1:0]      cmd_enter,
   output logic [CHANNELS-1:0]      sig_out,
   output logic [CHANNELS-1:0]      dial_handshake,
   output logic [CHANNELS-1:0]      dial_out_ok
);
   // local settings
   logic        role;          // primary when high
   logic        cfg_valid;     // parameter set valid
   logic [1:0]  link_speed;    // local link settings
   logic [31:0] shared;        // exchanged parameter word
   logic [7:0]  timeout;       // idle minutes
   logic [9:0]  esc_cfg;       // two escape chars
   logic        esc_two;       // two-char sequence
   logic [CHANNELS-1:0] idle_en, term_en, echo_en;
   logic [CHANNELS*2-1:0] ch_type;
   logic [CHANNELS*3-1:0] ch_sig;
   // sync, timers, sequencer
   logic [1:0]  sw_sync, link_sync;
   logic        sw_prev;
   logic [31:0] minute_cnt;
   logic        minute_tick;
   logic [7:0]  lost_min;
   logic        reinit;        // start exchange
   xchg_state_t state;
   logic [23:0] blink_cnt;
   logic        cmd_wr, setting_change;

   assign cmd_wr = reg_wr && reg_addr == reg_command;
   assign setting_change = reg_wr && ((reg_addr == reg_ctrl &&
      (reg_wdata[ctrl_role_bit] != role || reg_wdata[ctrl_valid_bit] != cfg_valid))
      || reg_addr == reg_link);

   // pin synchronisers
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sw_sync   <= 2'h0;
         link_sync <= 2'h0;
         sw_prev   <= 1'b0;
      end
      else
      begin
         sw_sync   <= {sw_sync[0], system_reset_switch};
         link_sync <= {link_sync[0], link_up};
         sw_prev   <= sw_sync[1];
      end
   end

   // minute tick from system clock
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         minute_cnt  <= 32'h0;
         minute_tick <= 1'b0;
      end
      else if (minute_cnt == 32'(MINUTE_CYCLES - 1))
      begin
         minute_cnt  <= 32'h0;
         minute_tick <= 1'b1;
      end
      else
      begin
         minute_cnt  <= minute_cnt + 32'h1;
         minute_tick <= 1'b0;
      end
   end

   // full reset and reinit requests
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         full_diag <= 1'b1;  // power application
         reinit    <= 1'b1;
         lost_min  <= 8'h00;
      end
      else
      begin
         full_diag <= (sw_sync[1] && !sw_prev)
            || (cmd_wr && reg_wdata[1]);
         reinit    <= (sw_sync[1] && !sw_prev) || (cmd_wr && reg_wdata[1:0] != 2'h0)
            || setting_change || (lost_min == 8'h01 && minute_tick);
         if (link_sync[1])
            lost_min <= 8'h00;
         else if (minute_tick && lost_min != 8'hff)
            lost_min <= lost_min + 8'h01;
      end
   end

   // register writes and exchange adoption
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         role       <= role_primary;
         cfg_valid  <= flag_valid;
         link_speed <= 2'h0;
         shared     <= {22'h0, 1'b0, pol_assert, stop_one, par_none, bits_eight, 2'h0};
         timeout    <= timeout_def;
         esc_cfg    <= {escape_def, escape_def};
         esc_two    <= 1'b1;
         idle_en    <= '0;
         term_en    <= '0;
         echo_en    <= '0;
         ch_type    <= '0;
         ch_sig     <= '0;
      end
      else if (state == st_wait && peer_strobe)
      begin
         // role, link speed and name kept local
         if ((!cfg_valid && peer_valid) ||
             (cfg_valid && peer_valid && !role && peer_role && peer_params != shared))
         begin
            shared    <= peer_params;
            cfg_valid <= 1'b1;
         end
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            reg_ctrl:
            begin
               role      <= reg_wdata[ctrl_role_bit];
               cfg_valid <= reg_wdata[ctrl_valid_bit];
               shared[9:2] <= {reg_wdata[ctrl_star_bit], reg_wdata[ctrl_pol_bit],
                  reg_wdata[ctrl_stop_lo +: 2] == 2'h3 ? stop_two : reg_wdata[ctrl_stop_lo +: 2],
                  reg_wdata[ctrl_par_lo +: 2] == 2'h3 ? par_none : reg_wdata[ctrl_par_lo +: 2],
                  reg_wdata[ctrl_bits_lo +: 2]};
            end
            reg_timeout: timeout <= (reg_wdata[7:0] < timeout_min) ? timeout_min : reg_wdata[7:0];
            reg_escape:
            begin
               esc_cfg <= {reg_wdata[12:8], reg_wdata[4:0]};
               esc_two <= reg_wdata[16];
            end
            reg_chan_cfg:
            begin
               idle_en <= reg_wdata[CHANNELS-1:0];
               term_en <= reg_wdata[8 +: CHANNELS];
               echo_en <= reg_wdata[16 +: CHANNELS];
               ch_type <= reg_wdata[24 +: CHANNELS*2];
            end
            reg_chan_sig: ch_sig <= reg_wdata[CHANNELS*3-1:0];
            reg_link:     link_speed <= reg_wdata[1:0];
            reg_shared:   shared[31:10] <= reg_wdata[31:10];
            default:      ;
         endcase
      end
   end

   // exchange sequencer
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         state <= st_idle;
      else if (reinit)
         state <= st_send;
      else
      begin
         case (state)
            st_idle: state <= st_idle;
            st_send: state <= st_wait;
            st_wait:
               if (peer_strobe)
               begin
                  if ((!cfg_valid && !peer_valid) || role == peer_role)
                     state <= st_fail;
                  else
                     state <= st_run;
               end
            st_fail: state <= st_fail;  // held until reinit restarts the exchange
            st_run:  state <= st_run;
            default: state <= st_idle;
         endcase
      end
   end

   // link words toward peer
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         tx_strobe <= 1'b0;
         tx_role   <= role_primary;
         tx_valid  <= flag_valid;
         tx_params <= 32'h0;
      end
      else
      begin
         tx_strobe <= (state == st_send);
         tx_role   <= role;
         tx_valid  <= cfg_valid;
         tx_params <= shared;
      end
   end

   // ready indicator and data gate
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         blink_cnt   <= 24'h0;
         ready_led   <= 1'b0;
         data_enable <= 1'b0;
      end
      else
      begin
         blink_cnt   <= blink_cnt + 24'h1;
         data_enable <= (state == st_run);
         ready_led   <= (state == st_fail) ? blink_cnt[23] : (state == st_run);
      end
   end

   // register read
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         reg_rdata <= 32'h0;
      else if (reg_rd)
      begin
         case (reg_addr)
            reg_ctrl:     reg_rdata <= {22'h0, shared[9:2], cfg_valid, role};
            reg_timeout:  reg_rdata <= {24'h0, timeout};
            reg_escape:   reg_rdata <= {15'h0, esc_two, 3'h0, esc_cfg[9:5], 3'h0, esc_cfg[4:0]};
            reg_status:   reg_rdata <= {16'h0, lost_min, 3'h0, state};
            reg_chan_cfg: reg_rdata <= 32'({ch_type, 8'(echo_en), 8'(term_en), 8'(idle_en)});
            reg_chan_sig: reg_rdata <= 32'(ch_sig);
            reg_link:     reg_rdata <= {30'h0, link_speed};
            reg_shared:   reg_rdata <= shared;
            default:      reg_rdata <= 32'h0;
         endcase
      end
      else
         reg_rdata <= 32'h0;
   end

   // per channel logic
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++)
      begin : g_chan
         chan_ctl u_chan (
            .sys_clk         (sys_clk),
            .sys_rst         (sys_rst),
            .chan_type       (ch_type[2*g +: 2]),
            .chan_sig        (ch_sig[3*g +: 3]),
            .sys_pol         (shared[ctrl_pol_bit]),
            .idle_en         (idle_en[g]),
            .term_en         (term_en[g]),
            .echo_en         (echo_en[g]),
            .timeout_min_cnt (timeout),
            .esc_a           (esc_cfg[4:0]),
            .esc_b           (esc_cfg[9:5]),
            .esc_two         (esc_two),
            .minute_tick     (minute_tick),
            .char_strobe     (char_strobe[g]),
            .char_data       (char_data),
            .data_allowed    (data_enable),
            .far_sigs        (far_sigs[g]),
            .idle_disc       (idle_disc[g]),
            .cmd_enter       (cmd_enter[g]),
            .sig_out         (sig_out[g]),
            .dial_handshake  (dial_handshake[g]),
            .dial_out_ok     (dial_out_ok[g])
         );
      end
   endgenerate
endmodule // mux_system_option_control
`default_nettype wire

// file: tb/sysopt_assertions.sv
// checker on the option control ports
// assumes one clock domain and an active high async reset
`timescale 1ns/10ps
`default_nettype none
module sysopt_assertions
#(
   parameter int CHANNELS = 4
)
(
   // clock and reset
   input wire logic                sys_clk,
   input wire logic                sys_rst,
   // watched ports
   input wire logic                reg_rd,
   input wire logic [31:0]         reg_rdata,
   input wire logic                system_reset_switch,
   input wire logic                peer_strobe,
   input wire logic                tx_strobe,
   input wire logic [CHANNELS-1:0] char_strobe,
   input wire logic                ready_led,
   input wire logic                data_enable,
   input wire logic                full_diag,
   input wire logic [CHANNELS-1:0] idle_disc,
   input wire logic [CHANNELS-1:0] cmd_enter
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   logic [1:0] age;  // cycles since reset release, saturating
   // age counter
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         age <= 2'h0;
      else if (age != 2'h3)
         age <= age + 2'h1;
   end
   sequence s_fresh; age == 2'h0; endsequence
   sequence s_send; ##[0:3] tx_strobe; endsequence
   property p_start; s_fresh |-> s_send; endproperty
   a_start: assert property (p_start) else $error("no exchange after reset");
   property p_tx_pulse; tx_strobe |=> !tx_strobe; endproperty
   a_tx_pulse: assert property (p_tx_pulse) else $error("exchange word too long");
   property p_rd_zero; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("read data outside slot");
   property p_de_cause; $rose(data_enable) |-> $past(peer_strobe, 2); endproperty
   a_de_cause: assert property (p_de_cause) else $error("data without exchange");
   property p_run_led; data_enable [*3] |-> ready_led; endproperty
   a_run_led: assert property (p_run_led) else $error("ready off while running");
   property p_diag; $rose(system_reset_switch) |-> ##[1:6] full_diag; endproperty
   a_diag: assert property (p_diag) else $error("switch gave no diagnostics");
   property p_cmd_cause;
      cmd_enter[0] |-> ($past(char_strobe[0]) || $past(char_strobe[0], 2));
   endproperty
   a_cmd_cause: assert property (p_cmd_cause) else $error("command mode without char");
   property p_cmd_pulse; cmd_enter[0] |=> !cmd_enter[0]; endproperty
   a_cmd_pulse: assert property (p_cmd_pulse) else $error("command entry too long");
   property p_idle_quiet; idle_disc[0] |-> !$past(char_strobe[0]); endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("disconnect after char");
endmodule // sysopt_assertions
bind mux_system_option_control sysopt_assertions #(.CHANNELS(CHANNELS)) u_chk (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .system_reset_switch(system_reset_switch), .peer_strobe(peer_strobe),
   .tx_strobe(tx_strobe), .char_strobe(char_strobe), .ready_led(ready_led),
   .data_enable(data_enable), .full_diag(full_diag), .idle_disc(idle_disc),
   .cmd_enter(cmd_enter));
`default_nettype wire

// file: tb/peer_unit_model.sv
// far unit: answers each exchange word after a set lag
// assumes words qualified by a one cycle strobe
`timescale 1ns/10ps
`default_nettype none
module peer_unit_model
(
   input wire logic        sys_clk,
   input wire logic        tx_strobe,
   input wire logic        role,      // 1 primary
   input wire logic        valid,
   input wire logic [31:0] params,
   input wire logic [3:0]  lag,       // reply delay in cycles
   output logic            peer_strobe,
   output logic            peer_role,
   output logic            peer_valid,
   output logic [31:0]     peer_params
);
   int cnt = -1;  // cycles to reply, -1 idle
   initial {peer_strobe, peer_role, peer_valid, peer_params} = '0;
   // reply one word per exchange, scramble lines between words
   always @(posedge sys_clk)
   begin
      peer_strobe <= 1'b0;
      peer_role   <= ~peer_role;
      peer_valid  <= ~peer_valid;
      peer_params <= ~peer_params;
      if (tx_strobe)
         cnt <= lag;
      else if (cnt == 0)
      begin
         peer_strobe <= 1'b1;
         peer_role   <= role;
         peer_valid  <= valid;
         peer_params <= params;
         cnt         <= -1;
      end
      else if (cnt > 0)
         cnt <= cnt - 1;
   end
endmodule // peer_unit_model
`default_nettype wire

// file: tb/mux_system_option_control_tb.sv
// bench for the option control block with a peer model
// assumes a 40 mhz clock and a 100 cycle minute
`timescale 1ns/10ps
`default_nettype none
module mux_system_option_control_tb;
   import sysopt_pkg::*;
   logic sys_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, srs = 0, link_up = 1;
   logic [3:0] reg_addr = 0, char_strobe = 0, far_sigs = 0;
   logic [31:0] reg_wdata = 0, reg_rdata, tx_params, peer_params, p_par = 32'h5a5a_0000;
   logic [7:0] char_data = 0;
   logic p_role = 0, p_val = 1, h;
   logic peer_strobe, peer_role, peer_valid, tx_strobe, tx_role, tx_valid;
   logic ready_led, data_enable, full_diag;
   logic [3:0] idle_disc, cmd_enter, sig_out, dial_handshake, dial_out_ok;
   int bad_count = 0, total_checks = 0, cyc = 0, idle0 = 0, idle3 = 0, fd = 0, txc = 0;
   typedef struct {logic [3:0] a; logic [31:0] e;} row_t;
   row_t rows[6] = '{'{4'h0, 32'hf}, '{4'h1, 32'h14}, '{4'h2, 32'h11c1c},
                     '{4'h4, 32'h10}, '{4'h6, 32'h0}, '{4'hc, 32'h0}};
   mux_system_option_control #(.CHANNELS(4), .MINUTE_CYCLES(100)) u_dut (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .system_reset_switch(srs),
      .link_up(link_up), .peer_strobe(peer_strobe), .peer_role(peer_role),
      .peer_valid(peer_valid), .peer_params(peer_params), .tx_strobe(tx_strobe),
      .tx_role(tx_role), .tx_valid(tx_valid), .tx_params(tx_params),
      .char_strobe(char_strobe), .char_data(char_data), .far_sigs(far_sigs),
      .ready_led(ready_led), .data_enable(data_enable), .full_diag(full_diag),
      .idle_disc(idle_disc), .cmd_enter(cmd_enter), .sig_out(sig_out),
      .dial_handshake(dial_handshake), .dial_out_ok(dial_out_ok));
   peer_unit_model u_peer (.sys_clk(sys_clk), .tx_strobe(tx_strobe), .role(p_role),
      .valid(p_val), .params(p_par), .lag(4'h3), .peer_strobe(peer_strobe),
      .peer_role(peer_role), .peer_valid(peer_valid), .peer_params(peer_params));
   initial forever #12.5 sys_clk = ~sys_clk;
   // watch counters and hang limit
   always @(posedge sys_clk)
   begin
      cyc++; idle0 += idle_disc[0]; idle3 += idle_disc[3]; fd += full_diag; txc += tx_strobe;
      if (cyc == 20000)
      begin
         bad_count++;
         close_out;
      end
   end
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge sys_clk) reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge sys_clk) {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge sys_clk) reg_rd <= 1'b0;
      #1 chk("register", e, reg_rdata & m);
   endtask
   // one char, then gather command entry over three cycles
   task automatic sendc(input int c, input logic [7:0] d, output logic hit);
      @(posedge sys_clk) {char_strobe, char_data} <= {4'(1 << c), d};
      @(posedge sys_clk) char_strobe <= 4'h0;
      #1 hit = cmd_enter[c];
      repeat (2) @(posedge sys_clk) #1 hit = hit | cmd_enter[c];
   endtask
   task automatic wait_de(input logic v);
      for (int i = 0; i < 60 && data_enable !== v; i++)
         @(posedge sys_clk) #1;
      chk("data_enable", {31'h0, v}, {31'h0, data_enable});
   endtask
   initial
   begin
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      wait_de(1'b1);
      foreach (rows[i]) rd(rows[i].a, 32'hffffffff, rows[i].e);
      p_role = 1'b1; wr(4'h3, 32'h1);
      repeat (20) @(posedge sys_clk);
      wait_de(1'b0);
      rd(4'h4, 32'h1f, 32'h08);
      p_role = 1'b0; wr(4'h0, 32'hd);
      repeat (10) @(posedge sys_clk);
      wait_de(1'b1);
      rd(4'h0, 32'hf, 32'h3);
      wr(4'h1, 32'h0);
      rd(4'h1, 32'hff, 32'h1);
      wr(4'h5, 32'h4903_0301);
      sendc(0, 8'h1c, h); sendc(0, 8'h1c, h); chk("cmd0", 1, h);
      sendc(0, 8'h1c, h); sendc(0, 8'h41, h); sendc(0, 8'h1c, h); chk("cmd0", 0, h);
      sendc(1, 8'h1c, h); sendc(1, 8'h1c, h); chk("cmd1", 0, h);
      sendc(2, 8'h1c, h); sendc(2, 8'h1c, h); chk("cmd2", 0, h);
      wr(4'h2, 32'h05);
      sendc(0, 8'h05, h); chk("cmd0", 1, h);
      wr(4'h1, 32'h2);
      idle0 = 0;
      repeat (8) begin sendc(0, 8'h41, h); repeat (36) @(posedge sys_clk); end
      chk("idle busy", 0, idle0);
      repeat (350) @(posedge sys_clk);
      chk("idle0", 1, 32'(idle0 > 0));
      chk("idle3", 0, idle3);
      chk("sig assert", 1, sig_out[3]);
      wr(4'h0, 32'h1cf);
      rd(4'h0, 32'h1cf, 32'h18f);
      chk("sig pass", 0, sig_out[3]);
      @(posedge sys_clk) far_sigs <= 4'h8;
      repeat (6) @(posedge sys_clk);
      chk("sig pass", 1, sig_out[3]);
      wr(4'h6, 32'ha00);
      repeat (2) @(posedge sys_clk);
      chk("dial", 2'h3, {dial_handshake[3], dial_out_ok[3]});
      wr(4'h6, 32'h800);
      repeat (2) @(posedge sys_clk);
      chk("dial", 2'h2, {dial_handshake[3], dial_out_ok[3]});
      fd = 0; srs <= 1'b1;
      repeat (10) @(posedge sys_clk);
      srs <= 1'b0;
      chk("diag", 1, 32'(fd > 0));
      wait_de(1'b1);
      p_role = 1'b1; wr(4'h0, 32'h0e);
      wait_de(1'b0); wait_de(1'b1);
      rd(4'h0, 32'hf, 32'h2);
      txc = 0;
      @(posedge sys_clk) link_up <= 1'b0;
      repeat (220) @(posedge sys_clk);
      link_up <= 1'b1;
      chk("link loss", 1, 32'(txc > 0));
      close_out;
   end
endmodule // mux_system_option_control_tb
`default_nettype wire
